/* File: verilog/zorr_pkg.sv */
// Purpose: Shared types and constants for the zero-order redundancy reducer.
// Assumes: 6-bit samples, 4-bit tolerance, 10-bit output words.
// Notes: Word-size and mode encodings are used by ports and logic alike.
package zorr_pkg;
	localparam int SAMPLE_W = 6;
	localparam int TOL_W = 4;
	localparam int WORD_W = 10;
	localparam int TAG_MAX_W = 6;
	localparam int SYNC_AMP_W = 4;
	// Forced-nonredundant limits per time tag size.
	localparam logic [TAG_MAX_W-1:0] LIMIT_TAG4 = 6'h0e;
	localparam logic [TAG_MAX_W-1:0] LIMIT_TAG5 = 6'h1e;
	localparam logic [TAG_MAX_W-1:0] LIMIT_TAG6 = 6'h3e;
	localparam logic [TAG_MAX_W-1:0] TAG_ZERO = 6'h00;
	localparam logic [TAG_MAX_W-1:0] TAG_ONE = 6'h01;
	// Sync amplitudes for horizontal and vertical blanking.
	localparam logic [SYNC_AMP_W-1:0] SYNC_AMP_HOR = 4'h5;
	localparam logic [SYNC_AMP_W-1:0] SYNC_AMP_VER = 4'ha;

	typedef enum logic [1:0] {
		ZORR_TAG4 = 2'b00,
		ZORR_TAG5 = 2'b01,
		ZORR_TAG6 = 2'b10
	} zorr_tag_size_e;

	typedef enum logic {
		ZORR_INTERPOLATOR_MODE = 1'b0,
		ZORR_PREDICTOR_MODE = 1'b1
	} zorr_mode_e;

	typedef struct packed {
		zorr_mode_e mode;
		zorr_tag_size_e tag_size;
		logic adaptive_tol;
		logic [TOL_W-1:0] fixed_tol;
	} zorr_cfg_s;

	typedef struct packed {
		logic valid;
		logic [SAMPLE_W-1:0] sample;
	} zorr_sample_s;

	typedef enum logic [1:0] {
		ZORR_RUN = 2'b00,
		ZORR_FIRST = 2'b01,
		ZORR_BLANK = 2'b10
	} zorr_state_e;
endpackage

/* File: verilog/zorr_word_packer.sv */
// Purpose: Packs a nonredundant value and its time tag into one 10-bit word.
// Assumes: Tag values never exceed the selected tag width.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module zorr_word_packer (
	input wire logic [zorr_pkg::SAMPLE_W-1:0] value_i,
	input wire logic [zorr_pkg::TAG_MAX_W-1:0] tag_i,
	input wire zorr_pkg::zorr_tag_size_e tag_size_i,
	output logic [zorr_pkg::WORD_W-1:0] word_o
);
	import zorr_pkg::*;

	always_comb begin
		unique case (tag_size_i)
			ZORR_TAG5: word_o = {value_i[5:1], tag_i[4], tag_i[3:0]};
			ZORR_TAG6: word_o = {value_i[5:2], tag_i[5:4], tag_i[3:0]};
			default: word_o = {value_i, tag_i[3:0]};
		endcase
	end
endmodule

/* File: verilog/zorr_reducer.sv */
// Purpose: Zero-order interpolator / predictor redundancy reducer for video samples.
// Assumes: Sample strobe is a pulse from the sample-rate divider; only its synchronised rising edge counts.
// Notes: One add/subtract and one compare per sample; mode only gates register loads.
// Notes on behaviour
// - One 6-bit sample accepted per sample strobe, 1 to 9 MHz rate.
// - Tolerance is 4 bits: fixed value or rate-adaptive value from buffer fill.
// - Every output word is 10 bits; word-size select chooses sample/tag split.
// - 4-bit tag: full 6-bit sample sits beside the tag unmodified.
// - 5-bit tag: top five sample bits; tag MSB replaces sample LSB.
// - 6-bit tag: top four sample bits; tag top two bits fill vacated positions.
// - One add/subtract then compare per step; modes share datapath, differ in gating.
// - Interpolator: after nonredundant, corridor loads upper and lower tolerance limits.
// - Interpolator: overlap means redundant, discard, increment repeat count.
// - Interpolator: redundant sample narrows corridor to the tighter bounds.
// - Interpolator: no overlap outputs corridor midpoint with repeat count.
// - Force nonredundant after 14, 30 or 62 periods for 4/5/6-bit tags.
// - Predictor: after nonredundant, current sample loads both corridor registers.
// - Predictor: overlap is redundant and corridor is left unchanged.
// - Predictor: no overlap outputs corridor midpoint, the previous nonredundant sample.
// - Predictor uses the same packing, word sizes and timeout as interpolator.
// - Blanking forces current sample nonredundant, then reduction is suspended.
// - During blanking a sync word goes out: zero 6-bit tag, 4-bit amplitude.
// - Buffer underflow forces the present sample nonredundant into the buffer.
// - First sample after blanking initialises the corridor per mode, no output.
`timescale 1ns/1ns
module zorr_reducer #(
	parameter int SAMPLE_W = zorr_pkg::SAMPLE_W,
	parameter int TOL_W = zorr_pkg::TOL_W
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic sample_stb_i,
	input wire logic [zorr_pkg::SAMPLE_W-1:0] adc_sample_i,
	input wire zorr_pkg::zorr_cfg_s cfg_i,
	input wire logic [zorr_pkg::TOL_W-1:0] adaptive_tol_i,
	input wire logic blank_i,
	input wire logic blank_vertical_i,
	input wire logic sync_req_i,
	input wire logic underflow_i,
	output logic word_valid_o,
	output logic [zorr_pkg::WORD_W-1:0] word_o,
	output logic sync_word_o,
	output logic blank_active_o,
	output logic [zorr_pkg::TAG_MAX_W-1:0] repeat_count_tag_o
);
	import zorr_pkg::*;

	// Sample, strobe, blank and underflow inputs pass two flops before use; sync request and config are used directly.
	logic [SAMPLE_W-1:0] sample_meta;
	logic [SAMPLE_W-1:0] sample_sync;
	logic [2:0] ctl_meta;
	logic [2:0] ctl_sync;
	logic stb_meta;
	logic stb_sync;
	logic stb_prev;
	logic blank_s;
	logic blank_vert_s;
	logic underflow_s;
	logic stb;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sample_meta <= '0;
			sample_sync <= '0;
			ctl_meta <= 3'h0;
			ctl_sync <= 3'h0;
			stb_meta <= 1'b0;
			stb_sync <= 1'b0;
			stb_prev <= 1'b0;
		end else begin
			sample_meta <= adc_sample_i;
			sample_sync <= sample_meta;
			ctl_meta <= {blank_i, blank_vertical_i, underflow_i};
			ctl_sync <= ctl_meta;
			stb_meta <= sample_stb_i;
			stb_sync <= stb_meta;
			stb_prev <= stb_sync;
		end
	end

	assign blank_s = ctl_sync[2];
	assign blank_vert_s = ctl_sync[1];
	assign underflow_s = ctl_sync[0];
	// Edge of the synchronised strobe so a long strobe still counts once.
	assign stb = stb_sync & ~stb_prev;

	// Tolerance selection.
	logic [TOL_W-1:0] tolerance;
	assign tolerance = cfg_i.adaptive_tol ? adaptive_tol_i : cfg_i.fixed_tol;

	// Corridor arithmetic carries one extra bit each way so limits never wrap.
	localparam int EXT_W = SAMPLE_W + 2;
	logic [SAMPLE_W-1:0] current_sample;
	logic signed [EXT_W-1:0] sample_ext;
	logic signed [EXT_W-1:0] tol_ext;
	logic signed [EXT_W-1:0] upper_tolerance_limit;
	logic signed [EXT_W-1:0] lower_tolerance_limit;
	logic signed [EXT_W-1:0] corr_upper;
	logic signed [EXT_W-1:0] corr_lower;
	logic signed [EXT_W-1:0] next_upper;
	logic signed [EXT_W-1:0] next_lower;
	logic signed [EXT_W:0] mid_sum;
	logic [SAMPLE_W-1:0] midpoint;
	logic overlap;

	assign current_sample = sample_sync;
	assign sample_ext = signed'({2'b00, current_sample});
	assign tol_ext = signed'({{(EXT_W-TOL_W){1'b0}}, tolerance});
	assign upper_tolerance_limit = sample_ext + tol_ext;
	assign lower_tolerance_limit = sample_ext - tol_ext;
	// Overlap check is only comparisons on the limits just formed.
	assign overlap = (lower_tolerance_limit <= corr_upper) &&
		(upper_tolerance_limit >= corr_lower);

	// Midpoint clamps to the sample range; a corridor can extend past the rails.
	always_comb begin
		logic signed [EXT_W:0] half;
		half = '0;
		mid_sum = {corr_upper[EXT_W-1], corr_upper} + {corr_lower[EXT_W-1], corr_lower};
		half = mid_sum >>> 1;
		if (half < 0) begin
			midpoint = '0;
		end else if (half > signed'({3'b000, {SAMPLE_W{1'b1}}})) begin
			midpoint = {SAMPLE_W{1'b1}};
		end else begin
			midpoint = half[SAMPLE_W-1:0];
		end
	end

	// Forced decision limit for the selected tag size.
	logic [TAG_MAX_W-1:0] tag_limit;
	always_comb begin
		unique case (cfg_i.tag_size)
			ZORR_TAG5: tag_limit = LIMIT_TAG5;
			ZORR_TAG6: tag_limit = LIMIT_TAG6;
			default: tag_limit = LIMIT_TAG4;
		endcase
	end

	// Control state.
	zorr_state_e state;
	logic [TAG_MAX_W-1:0] repeat_count_tag;
	logic sync_sent;
	logic in_run;
	logic forced;
	logic nonredundant;
	logic emit_video;
	logic emit_sync;

	assign in_run = (state == ZORR_RUN);
	assign forced = (repeat_count_tag >= tag_limit) || underflow_s || blank_s;
	assign nonredundant = !overlap || forced;
	assign emit_video = stb && in_run && nonredundant;
	assign emit_sync = (state == ZORR_BLANK) && !sync_sent && sync_req_i;

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state <= ZORR_FIRST;
		end else begin
			unique case (state)
				ZORR_RUN: begin
					if (stb && blank_s) begin
						state <= ZORR_BLANK;
					end
				end
				ZORR_BLANK: begin
					if (!blank_s) begin
						state <= ZORR_FIRST;
					end
				end
				ZORR_FIRST: begin
					if (blank_s) begin
						state <= ZORR_BLANK;
					end else if (stb) begin
						state <= ZORR_RUN;
					end
				end
				default: state <= ZORR_FIRST;
			endcase
		end
	end

	// One sync word per blanking interval, when the buffer asks for it.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			sync_sent <= 1'b0;
		end else if (state != ZORR_BLANK) begin
			sync_sent <= 1'b0;
		end else if (emit_sync) begin
			sync_sent <= 1'b1;
		end
	end

	// Corridor registers; the mode only changes which values get loaded.
	always_comb begin
		next_upper = corr_upper;
		next_lower = corr_lower;
		if (stb && (state == ZORR_FIRST || (in_run && nonredundant))) begin
			if (cfg_i.mode == ZORR_PREDICTOR_MODE) begin
				next_upper = sample_ext;
				next_lower = sample_ext;
			end else begin
				next_upper = upper_tolerance_limit;
				next_lower = lower_tolerance_limit;
			end
		end else if (stb && in_run && cfg_i.mode == ZORR_INTERPOLATOR_MODE) begin
			// Redundant sample: keep the most restrictive bounds.
			if (upper_tolerance_limit < corr_upper) begin
				next_upper = upper_tolerance_limit;
			end
			if (lower_tolerance_limit > corr_lower) begin
				next_lower = lower_tolerance_limit;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			corr_upper <= '0;
			corr_lower <= '0;
		end else begin
			corr_upper <= next_upper;
			corr_lower <= next_lower;
		end
	end

	// Repeat count restarts at every new corridor.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			repeat_count_tag <= TAG_ZERO;
		end else if (stb && (state == ZORR_FIRST || emit_video)) begin
			repeat_count_tag <= TAG_ZERO;
		end else if (stb && in_run) begin
			repeat_count_tag <= repeat_count_tag + TAG_ONE;
		end
	end

	logic [WORD_W-1:0] packed_word;
	zorr_word_packer u_packer (
		.value_i(midpoint),
		.tag_i(repeat_count_tag),
		.tag_size_i(cfg_i.tag_size),
		.word_o(packed_word)
	);

	// Output word register; sync words take a zero tag so any tag size decodes them.
	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			word_valid_o <= 1'b0;
			word_o <= '0;
			sync_word_o <= 1'b0;
		end else begin
			word_valid_o <= emit_video || emit_sync;
			sync_word_o <= emit_sync;
			if (emit_sync) begin
				word_o <= {blank_vert_s ? SYNC_AMP_VER : SYNC_AMP_HOR, TAG_ZERO};
			end else if (emit_video) begin
				word_o <= packed_word;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			blank_active_o <= 1'b0;
			repeat_count_tag_o <= TAG_ZERO;
		end else begin
			blank_active_o <= (state == ZORR_BLANK);
			repeat_count_tag_o <= repeat_count_tag;
		end
	end
endmodule

/* File: bench/zorr_reducer_chk.sv */
// Purpose: Port-level assertions for the redundancy reducer.
// Assumes: Strobes at least three clocks apart, tag size only changes across blanking.
// Notes: Bound to every reducer instance.
`timescale 1ns/1ns
module zorr_reducer_chk (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire zorr_pkg::zorr_cfg_s cfg_i,
	input wire logic blank_vertical_i,
	input wire logic sync_req_i,
	input wire logic word_valid_o,
	input wire logic [zorr_pkg::WORD_W-1:0] word_o,
	input wire logic sync_word_o,
	input wire logic blank_active_o,
	input wire logic [zorr_pkg::TAG_MAX_W-1:0] repeat_count_tag_o
);
	import zorr_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	a_sync_pairs: assert property (sync_word_o |-> word_valid_o)
		else $error("sync flag without a word");
	a_valid_pulse: assert property (word_valid_o |=> !word_valid_o)
		else $error("word valid longer than one cycle");
	a_word_holds: assert property (!word_valid_o |-> $stable(word_o))
		else $error("word changed without valid");
	a_sync_format: assert property (sync_word_o |->
		word_o == {blank_vertical_i ? SYNC_AMP_VER : SYNC_AMP_HOR, TAG_ZERO})
		else $error("bad sync word");
	a_sync_cause: assert property (sync_word_o |-> $past(sync_req_i) && blank_active_o)
		else $error("sync word without request");
	a_tag4_bound: assert property (word_valid_o && !sync_word_o
		&& cfg_i.tag_size == ZORR_TAG4 |-> word_o[3:0] <= LIMIT_TAG4[3:0])
		else $error("tag beyond limit");
	a_count_step: assert property ($changed(repeat_count_tag_o) |->
		repeat_count_tag_o == TAG_ZERO
		|| repeat_count_tag_o == $past(repeat_count_tag_o) + TAG_ONE)
		else $error("repeat count jumped");
	a_count_bound: assert property (cfg_i.tag_size == ZORR_TAG4 |->
		repeat_count_tag_o <= LIMIT_TAG4)
		else $error("repeat count over limit");
	a_blank_quiet: assert property (word_valid_o && blank_active_o
		&& $past(blank_active_o, 2) |-> sync_word_o)
		else $error("data word during blanking");
	cover property (sync_word_o);
	cover property (word_valid_o && cfg_i.mode == ZORR_PREDICTOR_MODE);
	cover property (word_valid_o && cfg_i.tag_size == ZORR_TAG6 && word_o[5:0] == LIMIT_TAG6);
endmodule
bind zorr_reducer zorr_reducer_chk zorr_reducer_chk_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
	.cfg_i(cfg_i), .blank_vertical_i(blank_vertical_i), .sync_req_i(sync_req_i),
	.word_valid_o(word_valid_o), .word_o(word_o), .sync_word_o(sync_word_o),
	.blank_active_o(blank_active_o), .repeat_count_tag_o(repeat_count_tag_o));

/* File: bench/zorr_adc_model.sv */
// Purpose: Converter model that presents one sample with its strobe.
// Assumes: A go pulse at most every eight clocks.
// Notes: Data is only held while the reducer may still capture it.
`timescale 1ns/1ns
module zorr_adc_model (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [zorr_pkg::SAMPLE_W-1:0] value_i,
	output logic stb_o,
	output logic [zorr_pkg::SAMPLE_W-1:0] sample_o
);
	import zorr_pkg::*;
	int n = 9;
	logic [SAMPLE_W-1:0] last = '0;
	always @(posedge clk_i) begin
		if (go_i) begin
			n <= 0;
			last <= value_i;
		end else if (n < 9) begin
			n <= n + 1;
		end
	end
	// Three cycles high so the synchroniser never loses the edge.
	assign stb_o = n < 3;
	// Lines flip after the hold time, so a late capture shows as a mismatch.
	assign sample_o = n < 6 ? last : ~last;
endmodule

/* File: bench/zorr_reducer_tb.sv */
// Purpose: Self-checking bench comparing the reducer with a behavioural model.
// Assumes: One sample every eight clocks, blanking between configurations.
// Notes: Each configuration ends with a blanking interval and its sync word.
`timescale 1ns/1ns
module zorr_reducer_tb;
	import zorr_pkg::*;
	logic clk_sys_i = 0, rst_i = 1, go = 0, stb, uf = 0, bl = 0, blv = 0, sreq = 0, wv, sw, ba;
	logic [5:0] smp_v = '0, adc, rc;
	logic [3:0] atol = '0;
	logic [9:0] w;
	zorr_cfg_s cfg = '0;
	int fail_count = 0, checks = 0, U = 0, L = 0, cnt = 0, st = 1;
	logic [10:0] q[$];
	initial forever #20 clk_sys_i = ~clk_sys_i;
	zorr_adc_model zorr_adc_model_inst (.clk_i(clk_sys_i), .go_i(go), .value_i(smp_v),
		.stb_o(stb), .sample_o(adc));
	zorr_reducer zorr_reducer_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .sample_stb_i(stb),
		.adc_sample_i(adc), .cfg_i(cfg), .adaptive_tol_i(atol), .blank_i(bl),
		.blank_vertical_i(blv), .sync_req_i(sreq), .underflow_i(uf), .word_valid_o(wv),
		.word_o(w), .sync_word_o(sw), .blank_active_o(ba), .repeat_count_tag_o(rc));
	task automatic tick(int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic chk(logic [10:0] seen, logic [10:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	function automatic logic [9:0] pack(logic [5:0] s, logic [5:0] g);
		case (cfg.tag_size)
			ZORR_TAG4: return {s, g[3:0]};
			ZORR_TAG5: return {s[5:1], g[4:0]};
			default: return {s[5:2], g};
		endcase
	endfunction
	task automatic smp(int v, bit u, bit b);
		int t, hi, lo, lim, m;
		t = cfg.adaptive_tol ? atol : cfg.fixed_tol;
		hi = v + t;
		lo = v - t;
		lim = cfg.tag_size == ZORR_TAG4 ? 14 : cfg.tag_size == ZORR_TAG5 ? 30 : 62;
		if (st == 0 && (lo > U || hi < L || u || b || cnt >= lim)) begin
			m = (U + L + 256) / 2 - 128;
			m = m < 0 ? 0 : m > 63 ? 63 : m;
			q.push_back({1'b0, pack(6'(m), 6'(cnt))});
			cnt = 0;
			st = 1;
		end else if (st == 0) begin
			cnt++;
			if (cfg.mode == ZORR_INTERPOLATOR_MODE) begin
				U = hi < U ? hi : U;
				L = lo > L ? lo : L;
			end
		end
		if (st == 1) begin
			U = cfg.mode == ZORR_PREDICTOR_MODE ? v : hi;
			L = cfg.mode == ZORR_PREDICTOR_MODE ? v : lo;
			st = 0;
		end
		if (b) st = 2;
		smp_v = 6'(v);
		uf = u;
		bl = b;
		go = 1;
		tick(1);
		go = 0;
		tick(7);
		uf = 0;
	endtask
	// Words are looked at mid-cycle, away from the edge that launches them.
	always @(negedge clk_sys_i) if (wv === 1'b1) chk({sw, w}, q.size() ? q.pop_front() : 'x);
	initial begin
		void'($urandom(41854));
		tick(12);
		rst_i = 0;
		tick(3);
		for (int c = 0; c < 6; c++) begin
			cfg = '{zorr_mode_e'(c % 2), zorr_tag_size_e'(c / 2), 1'($urandom), 4'($urandom)};
			atol = 4'($urandom);
			blv = 1'(c % 2);
			for (int i = 0; i < 90; i++) smp(i < 20 ? i / 4 * 9 + $urandom % 4 : 33, i == 7, 0);
			smp($urandom % 64, 0, 1);
			chk(ba, 1);
			smp(9, 0, 1);
			q.push_back({1'b1, c % 2 ? SYNC_AMP_VER : SYNC_AMP_HOR, 6'h00});
			sreq = 1;
			tick(2);
			sreq = 0;
			tick(3);
			bl = 0;
			st = 1;
			tick(4);
			$display("test %0d done", c);
		end
		tick(8);
		chk(11'(q.size()), 0);
		close_out;
	end
	initial begin
		tick(20000);
		chk(0, 1);
		close_out;
	end
endmodule
